/* File: rtl/dfw_regs.vh */
// dfw_regs.vh: select-word bit positions, fault and warning codes.
// assumes the includer only reads these macros; no logic is held here.
`ifndef DFW_REGS_VH
`define DFW_REGS_VH

// ****************************************
// select word bit positions
// ****************************************
`define DFW_FS1_CLOOP_BIT    8
`define DFW_FS1_PORT1_BIT    9
`define DFW_FS2_FDBK_BIT     0
`define DFW_FS2_EXTFLT_BIT   6
`define DFW_FS2_PLIM_BIT     9
`define DFW_FS2_MLIM_BIT     10
`define DFW_WS1_CLOOP_BIT    8
`define DFW_WS2_FDBK_BIT     0
`define DFW_WS2_EXTFLT_BIT   6
`define DFW_WS2_PLIM_BIT     9
`define DFW_WS2_MLIM_BIT     10

// ****************************************
// reset values of the select words
// ****************************************
`define DFW_SEL_RESET        16'h0000

// ****************************************
// fault and warning codes (decimal as displayed)
// ****************************************
`define DFW_CODE_NONE        16'd0
`define DFW_SF_CLOOP         16'd3040
`define DFW_SF_PLIM          16'd3057
`define DFW_SF_MLIM          16'd3058
`define DFW_SF_FDBK          16'd5048
`define DFW_SF_EXTFLT        16'd5054
`define DFW_SF_PORT1         16'd6041
`define DFW_WN_CLOOP         16'd3072
`define DFW_WN_PLIM          16'd3089
`define DFW_WN_MLIM          16'd3090
`define DFW_WN_FDBK          16'd5080
`define DFW_WN_EXTFLT        16'd5086

`endif

/* File: rtl/dfw_sync.v */
// dfw_sync.v: two-flop synchroniser for a group of pin-level inputs.
// assumes inputs are asynchronous levels; output lags by two clocks.
`default_nettype none

module dfw_sync #(
   parameter W = 1
) (
   input  wire         clk,   // system clock
   input  wire         srst,  // sync reset, high
   input  wire [W-1:0] d,     // async levels
   output wire [W-1:0] q      // synchronised levels
);

   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;

   always @(posedge clk) begin
      if (srst) begin
         meta_r <= {W{1'b0}};
         sync_r <= {W{1'b0}};
      end else begin
         meta_r <= d;
         sync_r <= meta_r;
      end
   end

   assign q = sync_r;

endmodule

`default_nettype wire

/* File: rtl/dfw_reporter.v */
// dfw_reporter.v: drive fault and warning reporter.
// assumes condition pins are asynchronous; select words and clears come
// from logic on clk.
//
// Behaviour
// [R1] current-loop loss, fsel1 bit8: soft fault 03040
// [R2] current-loop loss, wsel1 bit8: warning 03072
// [R3] parameter limit, fsel2 bit9: fault 03057
// [R4] math limit, fsel2 bit10: fault 03058
// [R5] parameter limit, wsel2 bit9: warning 03089
// [R6] math limit, wsel2 bit10: warning 03090
// [R7] feedback loss, fsel2 bit0: fault 05048
// [R8] feedback loss, wsel2 bit0: warning 05080
// [R9] external fault open, fsel2 bit6: fault 05054
// [R10] external fault open, wsel2 bit6: warning 05086
// [R11] port1 lost, mask set, fsel1 bit9: 06041
// [R12] cleared select bit suppresses that report
// [R13] codes latched until clear or reset
`default_nettype none
`include "dfw_regs.vh"

module dfw_reporter (
   input  wire        clk,                    // 25 MHz system clock
   input  wire        srst,                   // sync reset, high
   input  wire        current_loop_loss,      // current-loop input lost (pin)
   input  wire        param_limit,            // parameter-limit event (pin)
   input  wire        math_limit,             // math-limit event (pin)
   input  wire        fdbk_loss,              // speed feedback lost (pin)
   input  wire        ext_fault_open,         // external fault input open (pin)
   input  wire        port_one_adapter_lost,  // port 1 adapter gone (pin)
   input  wire        port_one_mask,          // logic mask bit for port 1
   input  wire [15:0] fault_sel1,             // first fault-select word
   input  wire [15:0] fault_sel2,             // second fault-select word
   input  wire [15:0] warn_sel1,              // first warning-select word
   input  wire [15:0] warn_sel2,              // second warning-select word
   input  wire        fault_clr,              // pulse: clear latched faults
   input  wire        warn_clr,               // pulse: clear latched warnings
   output wire [5:0]  fault_act,              // live enabled fault conditions
   output wire [4:0]  warn_act,               // live enabled warnings
   output reg  [5:0]  fault_stat_r,           // sticky fault bits
   output reg  [4:0]  warn_stat_r,            // sticky warning bits
   output reg  [15:0] fault_code_r,           // first latched fault code
   output reg  [15:0] warn_code_r,            // first latched warning code
   output wire        soft_fault,             // any fault latched
   output wire        warning                 // any warning latched
);

   // ****************************************
   // input synchronisation
   // ****************************************
   wire [5:0] cond_s;
   wire       cloop_s;
   wire       plim_s;
   wire       mlim_s;
   wire       fdbk_s;
   wire       ext_s;
   wire       port1_s;

   dfw_sync #(.W(6)) u_sync (
      .clk  (clk),
      .srst (srst),
      .d    ({port_one_adapter_lost, ext_fault_open, fdbk_loss,
              math_limit, param_limit, current_loop_loss}),
      .q    (cond_s)
   );

   assign cloop_s = cond_s[0];
   assign plim_s  = cond_s[1];
   assign mlim_s  = cond_s[2];
   assign fdbk_s  = cond_s[3];
   assign ext_s   = cond_s[4];
   assign port1_s = cond_s[5];

   // ****************************************
   // condition gating by select words
   // ****************************************
   // fault bits: 0 cloop, 1 plim, 2 mlim, 3 fdbk, 4 ext, 5 port1
   assign fault_act[0] = cloop_s & fault_sel1[`DFW_FS1_CLOOP_BIT];    // [R1]
   assign fault_act[1] = plim_s  & fault_sel2[`DFW_FS2_PLIM_BIT];     // [R3]
   assign fault_act[2] = mlim_s  & fault_sel2[`DFW_FS2_MLIM_BIT];     // [R4]
   assign fault_act[3] = fdbk_s  & fault_sel2[`DFW_FS2_FDBK_BIT];     // [R7]
   assign fault_act[4] = ext_s   & fault_sel2[`DFW_FS2_EXTFLT_BIT];   // [R9]
   // port mask is internal logic, not a pin, so it is read directly
   assign fault_act[5] = port1_s & port_one_mask
                         & fault_sel1[`DFW_FS1_PORT1_BIT];            // [R11]

   // warning bits: 0 cloop, 1 plim, 2 mlim, 3 fdbk, 4 ext
   assign warn_act[0] = cloop_s & warn_sel1[`DFW_WS1_CLOOP_BIT];      // [R2]
   assign warn_act[1] = plim_s  & warn_sel2[`DFW_WS2_PLIM_BIT];       // [R5]
   assign warn_act[2] = mlim_s  & warn_sel2[`DFW_WS2_MLIM_BIT];       // [R6]
   assign warn_act[3] = fdbk_s  & warn_sel2[`DFW_WS2_FDBK_BIT];       // [R8]
   assign warn_act[4] = ext_s   & warn_sel2[`DFW_WS2_EXTFLT_BIT];     // [R10]

   // ****************************************
   // code selection
   // ****************************************
   // lowest bit wins when several conditions arrive together
   reg [15:0] fault_new;
   reg [15:0] warn_new;

   always @* begin
      fault_new = `DFW_CODE_NONE;
      if (fault_act[0])
         fault_new = `DFW_SF_CLOOP;
      else if (fault_act[1])
         fault_new = `DFW_SF_PLIM;
      else if (fault_act[2])
         fault_new = `DFW_SF_MLIM;
      else if (fault_act[3])
         fault_new = `DFW_SF_FDBK;
      else if (fault_act[4])
         fault_new = `DFW_SF_EXTFLT;
      else if (fault_act[5])
         fault_new = `DFW_SF_PORT1;
   end

   always @* begin
      warn_new = `DFW_CODE_NONE;
      if (warn_act[0])
         warn_new = `DFW_WN_CLOOP;
      else if (warn_act[1])
         warn_new = `DFW_WN_PLIM;
      else if (warn_act[2])
         warn_new = `DFW_WN_MLIM;
      else if (warn_act[3])
         warn_new = `DFW_WN_FDBK;
      else if (warn_act[4])
         warn_new = `DFW_WN_EXTFLT;
   end

   // ****************************************
   // latched status
   // ****************************************
   // set beats clear: an event in the clear cycle stays latched
   reg [5:0]  fault_stat_nxt;
   reg [4:0]  warn_stat_nxt;
   reg [15:0] fault_code_nxt;
   reg [15:0] warn_code_nxt;

   always @* begin
      fault_stat_nxt = (fault_clr ? 6'h00 : fault_stat_r) | fault_act;   // [R13]
      warn_stat_nxt  = (warn_clr ? 5'h00 : warn_stat_r) | warn_act;      // [R13]
      fault_code_nxt = fault_clr ? `DFW_CODE_NONE : fault_code_r;
      warn_code_nxt  = warn_clr ? `DFW_CODE_NONE : warn_code_r;
      // keep the first code; a later one does not overwrite it
      if (fault_code_nxt == `DFW_CODE_NONE)
         fault_code_nxt = fault_new;                                   // [R12]
      if (warn_code_nxt == `DFW_CODE_NONE)
         warn_code_nxt = warn_new;                                     // [R12]
   end

   always @(posedge clk) begin
      if (srst) begin
         fault_stat_r <= 6'h00;
         warn_stat_r  <= 5'h00;
         fault_code_r <= `DFW_CODE_NONE;
         warn_code_r  <= `DFW_CODE_NONE;
      end else begin
         fault_stat_r <= fault_stat_nxt;
         warn_stat_r  <= warn_stat_nxt;
         fault_code_r <= fault_code_nxt;                               // [R13]
         warn_code_r  <= warn_code_nxt;                                // [R13]
      end
   end

   assign soft_fault = |fault_stat_r;
   assign warning    = |warn_stat_r;

endmodule

`default_nettype wire

/* File: verif/dfw_sense_model.sv */
// dfw_sense_model.sv: sensor side of the reporter, drives condition pins.
// assumes pin levels follow the bench's request one clock later.
`default_nettype none
module dfw_sense_model (
   input  wire logic       clk,  // system clock
   input  wire logic [5:0] cond, // requested conditions
   output var  logic [5:0] pins  // condition pin levels
);
   timeunit 1ns;
   timeprecision 1ps;
   // register so pins never move in the bench's own time step
   always @(posedge clk) pins <= cond;
endmodule
`default_nettype wire

/* File: verif/dfw_reporter_monitor.sv */
// dfw_reporter_monitor.sv: port assertions for the reporter.
// assumes every port is on clk; bound to the reporter below.
`default_nettype none
`include "dfw_regs.vh"
module dfw_reporter_monitor (
   input wire logic        clk,           // clock
   input wire logic        srst,          // sync reset
   input wire logic        param_limit,   // pin
   input wire logic        port_one_mask, // mask bit
   input wire logic [15:0] fault_sel1,    // select word
   input wire logic [15:0] fault_sel2,    // select word
   input wire logic [15:0] warn_sel2,     // select word
   input wire logic        fault_clr,     // clear pulse
   input wire logic        warn_clr,      // clear pulse
   input wire logic [5:0]  fault_act,     // live faults
   input wire logic [4:0]  warn_act,      // live warnings
   input wire logic [5:0]  fault_stat_r,  // sticky faults
   input wire logic [4:0]  warn_stat_r,   // sticky warnings
   input wire logic [15:0] fault_code_r,  // fault code
   input wire logic [15:0] warn_code_r,   // warning code
   input wire logic        soft_fault     // any fault
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   plim_cause_a: assert property (
      $rose(fault_act[1]) |-> $past(param_limit, 2) && fault_sel2[9])
      else $error("param fault without cause");
   port_gate_a: assert property (fault_act[5] |-> port_one_mask && fault_sel1[9])
      else $error("port one fault not gated");
   mlim_gate_a: assert property (!warn_sel2[10] |-> !warn_act[2])
      else $error("math warning while deselected");
   cloop_code_a: assert property (
      fault_act[0] && fault_code_r == 16'h0000 && !fault_clr |=> fault_code_r == `DFW_SF_CLOOP)
      else $error("loop fault code wrong");
   code_hold_a: assert property (
      fault_code_r != 16'h0000 && !fault_clr |=> $stable(fault_code_r))
      else $error("fault code moved");
   stat_sticky_a: assert property (
      !fault_clr |=> (fault_stat_r & $past(fault_stat_r)) == $past(fault_stat_r))
      else $error("fault bit dropped");
   warn_clear_a: assert property (
      warn_clr && warn_act == 5'h00 |=> warn_stat_r == 5'h00 && warn_code_r == 16'h0000)
      else $error("warning clear failed");
   fault_flag_a: assert property (soft_fault == (fault_stat_r != 6'h00))
      else $error("fault flag wrong");
endmodule
bind dfw_reporter dfw_reporter_monitor mon (.clk(clk), .srst(srst), .param_limit(param_limit),
   .port_one_mask(port_one_mask), .fault_sel1(fault_sel1), .fault_sel2(fault_sel2),
   .warn_sel2(warn_sel2), .fault_clr(fault_clr), .warn_clr(warn_clr), .fault_act(fault_act),
   .warn_act(warn_act), .fault_stat_r(fault_stat_r), .warn_stat_r(warn_stat_r),
   .fault_code_r(fault_code_r), .warn_code_r(warn_code_r), .soft_fault(soft_fault));
`default_nettype wire

/* File: verif/tb.sv */
// tb.sv: self-checking bench for the fault and warning reporter.
// assumes the sensor model above and codes from the shared header.
`default_nettype none
`include "dfw_regs.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, srst = 1'b1, mask = 1'b0, fclr = 1'b0, wclr = 1'b0;
   logic [5:0]  cond = 6'h00;
   logic [15:0] fs1 = 16'h0000, fs2 = 16'h0000, ws1 = 16'h0000, ws2 = 16'h0000;
   wire  [5:0]  pin, f_act, f_stat;
   wire  [4:0]  w_act, w_stat;
   wire  [15:0] f_code, w_code;
   wire         sf, wn;
   int          error_cnt = 0, n_compared = 0, cycles = 0;
   always #20 clk = ~clk;
   dfw_sense_model model (.clk(clk), .cond(cond), .pins(pin));
   dfw_reporter uut (.clk(clk), .srst(srst), .current_loop_loss(pin[0]), .param_limit(pin[1]),
      .math_limit(pin[2]), .fdbk_loss(pin[3]), .ext_fault_open(pin[4]),
      .port_one_adapter_lost(pin[5]), .port_one_mask(mask), .fault_sel1(fs1), .fault_sel2(fs2),
      .warn_sel1(ws1), .warn_sel2(ws2), .fault_clr(fclr), .warn_clr(wclr), .fault_act(f_act),
      .warn_act(w_act), .fault_stat_r(f_stat), .warn_stat_r(w_stat), .fault_code_r(f_code),
      .warn_code_r(w_code), .soft_fault(sf), .warning(wn));
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize;
      $display("compares %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // pin up, check, pin down, check sticky, clear both, check empty
   task automatic run(input logic [5:0] c, input logic [15:0] f1, f2, w1, w2,
                      input logic m, input logic [5:0] fa, input logic [4:0] wa,
                      input logic [15:0] ef, ew);
      @(posedge clk);
      {fs1, fs2, ws1, ws2, mask, cond} <= {f1, f2, w1, w2, m, c};
      repeat (6) @(posedge clk);
      @(negedge clk);
      chk("fault code", f_code, ef);
      chk("warning code", w_code, ew);
      chk("live faults", {10'h000, f_act}, {10'h000, fa});
      chk("live warnings", {11'h000, w_act}, {11'h000, wa});
      @(posedge clk);
      cond <= 6'h00;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("held fault", f_code, ef);
      chk("held warning", w_code, ew);
      chk("sticky faults", {10'h000, f_stat}, {10'h000, fa});
      chk("sticky warnings", {11'h000, w_stat}, {11'h000, wa});
      chk("fault flag", {15'h0000, sf}, {15'h0000, ef != 16'h0000});
      chk("warning flag", {15'h0000, wn}, {15'h0000, ew != 16'h0000});
      @(posedge clk);
      {fclr, wclr} <= 2'b11;
      @(posedge clk);
      {fclr, wclr} <= 2'b00;
      @(negedge clk);
      chk("cleared fault", f_code, 16'h0000);
      chk("cleared warning", w_code, 16'h0000);
      chk("cleared bits", {5'h00, f_stat, w_stat}, 16'h0000);
      chk("cleared flags", {14'h0000, sf, wn}, 16'h0000);
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      // runs need about 150 cycles
      if (cycles == 1000) begin
         error_cnt++;
         summarize();
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      run(6'h01, 16'h0100, 16'h0000, 16'h0100, 16'h0000, 1'b0, 6'h01, 5'h01,
          `DFW_SF_CLOOP, `DFW_WN_CLOOP);
      run(6'h02, 16'h0000, 16'h0200, 16'h0000, 16'h0200, 1'b0, 6'h02, 5'h02,
          `DFW_SF_PLIM, `DFW_WN_PLIM);
      run(6'h04, 16'h0000, 16'h0400, 16'h0000, 16'h0400, 1'b0, 6'h04, 5'h04,
          `DFW_SF_MLIM, `DFW_WN_MLIM);
      run(6'h08, 16'h0000, 16'h0001, 16'h0000, 16'h0001, 1'b0, 6'h08, 5'h08,
          `DFW_SF_FDBK, `DFW_WN_FDBK);
      run(6'h10, 16'h0000, 16'h0040, 16'h0000, 16'h0040, 1'b0, 6'h10, 5'h10,
          `DFW_SF_EXTFLT, `DFW_WN_EXTFLT);
      run(6'h20, 16'h0200, 16'h0000, 16'h0000, 16'h0000, 1'b1, 6'h20, 5'h00,
          `DFW_SF_PORT1, 16'h0000);
      run(6'h20, 16'h0200, 16'h0000, 16'h0000, 16'h0000, 1'b0, 6'h00, 5'h00,
          16'h0000, 16'h0000);
      run(6'h06, 16'h0000, 16'h0600, 16'h0000, 16'h0600, 1'b0, 6'h06, 5'h06,
          `DFW_SF_PLIM, `DFW_WN_PLIM);
      run(6'h02, 16'hFFFF, 16'hFDFF, 16'hFFFF, 16'hFDFF, 1'b1, 6'h00, 5'h00,
          16'h0000, 16'h0000);
      // reset in mid-run with the condition still up, then a clear that the set beats
      @(posedge clk);
      {fs1, ws1, cond} <= {16'h0100, 16'h0100, 6'h01};
      repeat (6) @(posedge clk);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(negedge clk);
      chk("reset fault code", f_code, 16'h0000);
      chk("reset warning code", w_code, 16'h0000);
      chk("reset bits", {5'h00, f_stat, w_stat}, 16'h0000);
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("relatched fault", f_code, `DFW_SF_CLOOP);
      @(posedge clk);
      fclr <= 1'b1;
      @(posedge clk);
      fclr <= 1'b0;
      @(negedge clk);
      chk("fault after clear", f_code, `DFW_SF_CLOOP);
      chk("bits after clear", {10'h000, f_stat}, 16'h0001);
      summarize();
   end
endmodule
`default_nettype wire
